// >>> hif_pkg.sv
// Shared constants for the host control register bank
package hif_pkg;

	// ==========================================================
	// Register byte offsets
	localparam logic [7:0] ADDR_IRQ_ENABLE  = 8'h5c;
	localparam logic [7:0] ADDR_BYTE_ORDER  = 8'h64;
	localparam logic [7:0] ADDR_FIFO_THRESH = 8'h68;
	localparam logic [7:0] ADDR_RX_CONFIG   = 8'h6c;

	// ==========================================================
	// Reset values and constants
	localparam logic [31:0] BYTE_ORDER_WORD   = 32'h8765_4321;
	localparam logic [31:0] IRQ_ENABLE_RESET  = 32'h0000_0000;
	localparam logic [31:0] IRQ_ENABLE_WMASK  = 32'h83bf_efff;
	localparam logic [31:0] FIFO_THRESH_RESET = 32'h4800_0000;
	localparam logic [31:0] RX_CONFIG_RESET   = 32'h0000_0000;
	localparam logic [31:0] RX_CONFIG_WMASK   = 32'hcfff_1f00;

	// ==========================================================
	// Interrupt enable field positions
	localparam int EN_SOFTWARE       = 31;
	localparam int EN_TX_HALTED      = 25;
	localparam int EN_RX_HALTED      = 24;
	localparam int EN_DROP_HALF      = 23;
	localparam int EN_TX_COMPLETION  = 21;
	localparam int EN_RX_DMA         = 20;
	localparam int EN_GENERAL_TIMER  = 19;
	localparam int EN_PHY_EVENT      = 18;
	localparam int EN_POWER_EVENT    = 17;
	localparam int EN_TX_STATUS_OVF  = 16;
	localparam int EN_RX_WATCHDOG    = 15;
	localparam int EN_RX_ERROR       = 14;
	localparam int EN_TX_ERROR       = 13;
	localparam int EN_TX_UNDERRUN    = 11;
	localparam int EN_TX_OVERRUN     = 10;
	localparam int EN_TX_SPACE_AVAIL = 9;
	localparam int EN_TX_STATUS_FULL = 8;
	localparam int EN_TX_STATUS_LVL  = 7;
	localparam int EN_RX_DROPPED     = 6;
	localparam int EN_RX_DATA_LVL    = 5;
	localparam int EN_RX_STATUS_FULL = 4;
	localparam int EN_RX_STATUS_LVL  = 3;
	localparam int EN_GPIO_LSB       = 0;

	// ==========================================================
	// Threshold field positions (lsb, all 8 bits wide)
	localparam int THR_TX_SPACE_LSB  = 24;
	localparam int THR_TX_STATUS_LSB = 16;
	localparam int THR_RX_SPACE_LSB  = 8;
	localparam int THR_RX_STATUS_LSB = 0;

	// ==========================================================
	// Receive configuration field positions
	localparam int RXC_ALIGN_LSB  = 30;
	localparam int RXC_DMA_LSB    = 16;
	localparam int RXC_DMA_W      = 12;
	localparam int RXC_FLUSH_BIT  = 15;
	localparam int RXC_OFFSET_LSB = 8;

	// End alignment selections
	typedef enum logic [1:0] {
		ALIGN_4   = 2'b00,
		ALIGN_16  = 2'b01,
		ALIGN_32  = 2'b10,
		ALIGN_RSV = 2'b11
	} hif_align_e;

endpackage

// >>> hif_pad_calc.sv
// Filler dword count needed to reach the selected end alignment
`timescale 1ns/10ps
`default_nettype none
module hif_pad_calc (
	// Alignment select
	input  wire logic [1:0] align_sel,
	// Dwords already sent in this buffer, low bits
	input  wire logic [2:0] dwords_sent,
	// Filler dwords to append
	output var  logic [2:0] pad_dwords
);
	// ==========================================================
	// Pad computation
	always_comb begin
		unique case (align_sel)
			hif_pkg::ALIGN_16: pad_dwords = 3'(3'h0 - {1'b0, dwords_sent[1:0]}) & 3'h3;
			hif_pkg::ALIGN_32: pad_dwords = 3'(3'h0 - dwords_sent);
			// Reserved code falls back to plain dword alignment
			default:           pad_dwords = 3'h0;
		endcase
	end
endmodule // hif_pad_calc
`default_nettype wire

// >>> hif_regs.sv
// Host control register bank: irq mask, byte test, fifo levels, rx config
// ==========================================================
// Notes on behaviour
// - Set enable bit lets source reach irq
// - Status keeps recording; mask gates output only
// - Enables at bits 31, 25, 24, 23
// - Enables at bits 21 down to 16
// - Enables 15-13; bits 12,22,30-26 read-only
// - Enables at bits 11 down to 7
// - Enables at bits 6-3 and gpio 2-0
// - Byte test reads constant 87654321h always
// - Tx space irq when free above threshold
// - Tx status irq when used above threshold
// - Rx data irq when free below threshold
// - Rx status irq when used above threshold
// - End alignment field selects 4/16/32 bytes
// - Filler dwords appended; host discards them
// - Dma count decrements per dword, irq at end
// - New dma count accepted mid countdown
// - Flush bit clears both rx fifos, self-clears
// - Offset field shifts packet start 0-31 bytes
// - Offset upper bits apply on next dword
`timescale 1ns/10ps
`default_nettype none
module hif_regs #(
	parameter int LEVEL_W = 8
) (
	// Clock and reset
	input  wire logic               mclk,
	input  wire logic               resetn,
	// Wishbone classic slave
	input  wire logic               wb_cyc_i,
	input  wire logic               wb_stb_i,
	input  wire logic               wb_we_i,
	input  wire logic [7:0]         wb_adr_i,
	input  wire logic [3:0]         wb_sel_i,
	input  wire logic [31:0]        wb_dat_i,
	output logic      [31:0]        wb_dat_o,
	output logic                    wb_ack_o,
	// Interrupt status from the status register
	input  wire logic [31:0]        interrupt_status_register,
	output logic                    host_irq,
	// Fifo occupancy
	input  wire logic [LEVEL_W-1:0] tx_data_free_blocks,
	input  wire logic [LEVEL_W-1:0] tx_status_used,
	input  wire logic [LEVEL_W-1:0] rx_data_free_blocks,
	input  wire logic [LEVEL_W-1:0] rx_status_used,
	output logic                    tx_space_available_irq,
	output logic                    tx_status_level_irq,
	output logic                    rx_data_level_irq,
	output logic                    rx_status_level_irq,
	// Receive engine
	input  wire logic               rx_dword_read,
	input  wire logic               rx_buffer_end,
	input  wire logic [2:0]         rx_buffer_dwords,
	output logic                    rx_dma_done,
	output logic                    rx_fifo_flush,
	output logic [1:0]              rx_end_align,
	output logic [2:0]              rx_pad_dwords,
	output logic                    rx_pad_valid,
	output logic [4:0]              receive_start_offset
);
	// ==========================================================
	// State
	typedef struct packed {
		logic [31:0] irq_en;
		logic [31:0] thresh;
		logic [31:0] rx_cfg;
		logic [31:0] rdata;
		logic        ack;
		logic        irq;
		logic        tx_space;
		logic        tx_status;
		logic        rx_data;
		logic        rx_status;
		logic        dma_done;
		logic        flush;
		logic [2:0]  pad;
		logic        pad_valid;
		logic [4:0]  offset;
	} hif_state_s;

	hif_state_s  st_q;
	hif_state_s  st_d;
	logic [31:0] lane_mask;
	logic [2:0]  pad_calc;
	logic [31:0] en_view;
	logic [31:0] irq_term;
	logic [7:0]  thr_tx_space;
	logic [7:0]  thr_tx_status;
	logic [7:0]  thr_rx_space;
	logic [7:0]  thr_rx_status;
	logic [1:0]  cfg_align;
	logic [hif_pkg::RXC_DMA_W-1:0] cfg_dma;
	logic [4:0]  cfg_offset;

	// ==========================================================
	// Byte lane mask from wishbone select
	genvar gi;
	generate
		for (gi = 0; gi < 32; gi++) begin : g_lane
			assign lane_mask[gi] = wb_sel_i[gi / 8];
		end
	endgenerate

	hif_pad_calc u_pad (
		.align_sel   (st_q.rx_cfg[hif_pkg::RXC_ALIGN_LSB +: 2]),
		.dwords_sent (rx_buffer_dwords),
		.pad_dwords  (pad_calc)
	);

	// ==========================================================
	// Threshold fields
	assign thr_tx_space  = st_q.thresh[hif_pkg::THR_TX_SPACE_LSB +: 8];
	assign thr_tx_status = st_q.thresh[hif_pkg::THR_TX_STATUS_LSB +: 8];
	assign thr_rx_space  = st_q.thresh[hif_pkg::THR_RX_SPACE_LSB +: 8];
	assign thr_rx_status = st_q.thresh[hif_pkg::THR_RX_STATUS_LSB +: 8];

	// ==========================================================
	// Receive config fields
	assign cfg_align     = st_q.rx_cfg[hif_pkg::RXC_ALIGN_LSB +: 2];
	assign cfg_dma       = st_q.rx_cfg[hif_pkg::RXC_DMA_LSB +: hif_pkg::RXC_DMA_W];
	assign cfg_offset    = st_q.rx_cfg[hif_pkg::RXC_OFFSET_LSB +: 5];

	// ==========================================================
	// Per-source interrupt terms
	// one AND term per source
	generate
		for (gi = 0; gi < 32; gi++) begin : g_irq
			assign irq_term[gi] = interrupt_status_register[gi] & st_q.irq_en[gi];
		end
	endgenerate

	// ==========================================================
	// Enable readback, field by field
	// Reserved positions stay zero whatever the flops hold
	always_comb begin
		en_view = 32'h0000_0000;
		en_view[hif_pkg::EN_SOFTWARE] = st_q.irq_en[hif_pkg::EN_SOFTWARE];
		en_view[hif_pkg::EN_TX_HALTED] = st_q.irq_en[hif_pkg::EN_TX_HALTED];
		en_view[hif_pkg::EN_RX_HALTED] = st_q.irq_en[hif_pkg::EN_RX_HALTED];
		en_view[hif_pkg::EN_DROP_HALF] = st_q.irq_en[hif_pkg::EN_DROP_HALF];
		en_view[hif_pkg::EN_TX_COMPLETION] = st_q.irq_en[hif_pkg::EN_TX_COMPLETION];
		en_view[hif_pkg::EN_RX_DMA] = st_q.irq_en[hif_pkg::EN_RX_DMA];
		en_view[hif_pkg::EN_GENERAL_TIMER] = st_q.irq_en[hif_pkg::EN_GENERAL_TIMER];
		en_view[hif_pkg::EN_PHY_EVENT] = st_q.irq_en[hif_pkg::EN_PHY_EVENT];
		en_view[hif_pkg::EN_POWER_EVENT] = st_q.irq_en[hif_pkg::EN_POWER_EVENT];
		en_view[hif_pkg::EN_TX_STATUS_OVF] = st_q.irq_en[hif_pkg::EN_TX_STATUS_OVF];
		en_view[hif_pkg::EN_RX_WATCHDOG] = st_q.irq_en[hif_pkg::EN_RX_WATCHDOG];
		en_view[hif_pkg::EN_RX_ERROR] = st_q.irq_en[hif_pkg::EN_RX_ERROR];
		en_view[hif_pkg::EN_TX_ERROR] = st_q.irq_en[hif_pkg::EN_TX_ERROR];
		en_view[hif_pkg::EN_TX_UNDERRUN] = st_q.irq_en[hif_pkg::EN_TX_UNDERRUN];
		en_view[hif_pkg::EN_TX_OVERRUN] = st_q.irq_en[hif_pkg::EN_TX_OVERRUN];
		en_view[hif_pkg::EN_TX_SPACE_AVAIL] = st_q.irq_en[hif_pkg::EN_TX_SPACE_AVAIL];
		en_view[hif_pkg::EN_TX_STATUS_FULL] = st_q.irq_en[hif_pkg::EN_TX_STATUS_FULL];
		en_view[hif_pkg::EN_TX_STATUS_LVL] = st_q.irq_en[hif_pkg::EN_TX_STATUS_LVL];
		en_view[hif_pkg::EN_RX_DROPPED] = st_q.irq_en[hif_pkg::EN_RX_DROPPED];
		en_view[hif_pkg::EN_RX_DATA_LVL] = st_q.irq_en[hif_pkg::EN_RX_DATA_LVL];
		en_view[hif_pkg::EN_RX_STATUS_FULL] = st_q.irq_en[hif_pkg::EN_RX_STATUS_FULL];
		en_view[hif_pkg::EN_RX_STATUS_LVL] = st_q.irq_en[hif_pkg::EN_RX_STATUS_LVL];
		en_view[hif_pkg::EN_GPIO_LSB +: 3] = st_q.irq_en[hif_pkg::EN_GPIO_LSB +: 3];
	end

	// ==========================================================
	// Next state
	always_comb begin
		logic                       req;
		logic                       wr;
		logic [31:0]                wm;
		logic [hif_pkg::RXC_DMA_W-1:0] cnt;
		logic                       dma_wr;
		req    = 1'b0;
		wr     = 1'b0;
		wm     = 32'h0000_0000;
		cnt    = '0;
		dma_wr = 1'b0;
		st_d   = st_q;

		// ==========================================================
		// Bus request
		// Single cycle answer, dropped the cycle after
		req     = wb_cyc_i & wb_stb_i & ~st_q.ack;
		wr      = req & wb_we_i;
		st_d.ack = req;
		st_d.flush = 1'b0;
		st_d.dma_done = 1'b0;
		st_d.pad_valid = 1'b0;

		// ==========================================================
		// Read decode
		if (req) begin
			unique case (wb_adr_i)
				hif_pkg::ADDR_IRQ_ENABLE: begin
					st_d.rdata = en_view;
				end
				hif_pkg::ADDR_BYTE_ORDER: begin
					st_d.rdata = hif_pkg::BYTE_ORDER_WORD;
				end
				hif_pkg::ADDR_FIFO_THRESH: begin
					st_d.rdata = st_q.thresh;
				end
				hif_pkg::ADDR_RX_CONFIG: begin
					st_d.rdata = st_q.rx_cfg;
				end
				// Unmapped reads zero and writes are dropped
				default: begin
					st_d.rdata = 32'h0000_0000;
				end
			endcase
		end

		// ==========================================================
		// Write decode
		if (wr) begin
			unique case (wb_adr_i)
				hif_pkg::ADDR_IRQ_ENABLE: begin
					wm = lane_mask & hif_pkg::IRQ_ENABLE_WMASK;
					st_d.irq_en = (st_q.irq_en & ~wm) | (wb_dat_i & wm);
				end
				hif_pkg::ADDR_BYTE_ORDER: begin
					wm = 32'h0000_0000;
				end
				hif_pkg::ADDR_FIFO_THRESH: begin
					// All four levels fully writable
					wm = lane_mask;
					st_d.thresh = (st_q.thresh & ~wm) | (wb_dat_i & wm);
				end
				hif_pkg::ADDR_RX_CONFIG: begin
					wm = lane_mask & hif_pkg::RX_CONFIG_WMASK;
					st_d.rx_cfg = (st_q.rx_cfg & ~wm) | (wb_dat_i & wm);
					dma_wr = wb_sel_i[2] | wb_sel_i[3];
					st_d.flush = wb_sel_i[1] & wb_dat_i[hif_pkg::RXC_FLUSH_BIT];
				end
				default: begin
					wm = 32'h0000_0000;
				end
			endcase
		end

		// ==========================================================
		// Receive dma countdown
		// count down per dword read
		// host write wins over the decrement
		cnt = cfg_dma;
		if (!dma_wr && rx_dword_read && cnt != '0) begin
			st_d.rx_cfg[hif_pkg::RXC_DMA_LSB +: hif_pkg::RXC_DMA_W] =
				hif_pkg::RXC_DMA_W'(cnt - 1'b1);
			st_d.dma_done = (cnt == hif_pkg::RXC_DMA_W'(1));
		end

		// ==========================================================
		// Start offset
		// start offset in bytes
		// low bits follow directly, host keeps them still
		st_d.offset[1:0] = st_q.rx_cfg[hif_pkg::RXC_OFFSET_LSB +: 2];
		// dword part taken at next dword read
		if (rx_dword_read) begin
			st_d.offset[4:2] = st_q.rx_cfg[hif_pkg::RXC_OFFSET_LSB + 2 +: 3];
		end

		// ==========================================================
		// End padding
		// filler count offered at buffer end
		// alignment assumed steady within a packet
		if (rx_buffer_end) begin
			st_d.pad       = pad_calc;
			st_d.pad_valid = 1'b1;
		end

		// ==========================================================
		// Host interrupt
		// enabled sources only
		// status bits are never touched here
		st_d.irq = |irq_term;

		// ==========================================================
		// Fifo level interrupts
		// tx free above level
		st_d.tx_space  = tx_data_free_blocks >
			LEVEL_W'(thr_tx_space);
		st_d.tx_status = tx_status_used >
			LEVEL_W'(thr_tx_status);
		st_d.rx_data   = rx_data_free_blocks <
			LEVEL_W'(thr_rx_space);
		st_d.rx_status = rx_status_used >
			LEVEL_W'(thr_rx_status);
	end

	// ==========================================================
	// Registers
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			st_q        <= '0;
			st_q.irq_en <= hif_pkg::IRQ_ENABLE_RESET;
			st_q.thresh <= hif_pkg::FIFO_THRESH_RESET;
			st_q.rx_cfg <= hif_pkg::RX_CONFIG_RESET;
		end else begin
			st_q <= st_d;
		end
	end

	// ==========================================================
	// Outputs, all straight from flops
	// Bus answer
	assign wb_dat_o               = st_q.rdata;
	assign wb_ack_o               = st_q.ack;

	// Interrupt request and fifo levels
	assign host_irq               = st_q.irq;
	assign tx_space_available_irq = st_q.tx_space;
	assign tx_status_level_irq    = st_q.tx_status;
	assign rx_data_level_irq      = st_q.rx_data;
	assign rx_status_level_irq    = st_q.rx_status;

	// Receive engine
	assign rx_dma_done            = st_q.dma_done;
	assign rx_fifo_flush          = st_q.flush;
	assign rx_end_align           = st_q.rx_cfg[hif_pkg::RXC_ALIGN_LSB +: 2];
	assign rx_pad_dwords          = st_q.pad;
	assign rx_pad_valid           = st_q.pad_valid;
	assign receive_start_offset   = st_q.offset;
endmodule // hif_regs
`default_nettype wire

// >>> hif_regs_checker.sv
// Port-level assertions for the host register bank
`timescale 1ns/10ps
`default_nettype none
module hif_regs_checker (
	// Bus, clock and receive engine
	input wire logic        mclk,
	input wire logic        resetn,
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_we_i,
	input wire logic [7:0]  wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic        wb_ack_o,
	input wire logic        rx_dword_read,
	input wire logic        rx_buffer_end,
	input wire logic        rx_dma_done,
	input wire logic        rx_fifo_flush,
	input wire logic [1:0]  rx_end_align,
	input wire logic        rx_pad_valid,
	input wire logic [4:0]  receive_start_offset
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!resetn);
	wire logic rd_ack = wb_ack_o && !wb_we_i;
	wire logic cfg_wr = wb_cyc_i && wb_we_i && wb_adr_i == hif_pkg::ADDR_RX_CONFIG;
	// ==========================================================
	// Assertions
	a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held too long");
	a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("request not acknowledged");
	a_byte_word: assert property (rd_ack && wb_adr_i == hif_pkg::ADDR_BYTE_ORDER
		|-> wb_dat_o == 32'h8765_4321) else $error("byte test word wrong");
	a_enable_reserved: assert property (rd_ack && wb_adr_i == hif_pkg::ADDR_IRQ_ENABLE
		|-> (wb_dat_o & 32'h7c40_1000) == 32'h0000_0000) else $error("enable reserved set");
	a_flush_zero: assert property (rd_ack && wb_adr_i == hif_pkg::ADDR_RX_CONFIG
		|-> !wb_dat_o[15]) else $error("flush bit reads one");
	a_flush_cause: assert property (rx_fifo_flush |-> $past(cfg_wr && wb_dat_i[15]))
		else $error("flush without write");
	a_pad_after_end: assert property (rx_pad_valid |-> $past(rx_buffer_end))
		else $error("pad without buffer end");
	a_align_write: assert property ($changed(rx_end_align) |-> $past(cfg_wr))
		else $error("alignment changed alone");
	a_dma_by_read: assert property (rx_dma_done |-> $past(rx_dword_read))
		else $error("dma done without read");
	a_offset_dword: assert property ($changed(receive_start_offset[4:2])
		|-> $past(rx_dword_read)) else $error("offset moved without read");
	c_byte_read: cover property (rd_ack && wb_adr_i == hif_pkg::ADDR_BYTE_ORDER);
	c_flush: cover property (rx_fifo_flush);
	c_dma_done: cover property (rx_dma_done);
endmodule // hif_regs_checker
bind hif_regs hif_regs_checker i_hif_regs_checker (.mclk, .resetn, .wb_cyc_i, .wb_stb_i,
	.wb_we_i, .wb_adr_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .rx_dword_read, .rx_buffer_end,
	.rx_dma_done, .rx_fifo_flush, .rx_end_align, .rx_pad_valid, .receive_start_offset);
`default_nettype wire

// >>> hif_host.sv
// Host processor model issuing classic Wishbone single cycles
`timescale 1ns/10ps
`default_nettype none
module hif_host (
	// Clock and slave answer
	input  wire logic        mclk,
	input  wire logic        wb_ack_o,
	input  wire logic [31:0] wb_dat_o,
	// Request
	output var  logic        wb_cyc_i,
	output var  logic        wb_stb_i,
	output var  logic        wb_we_i,
	output var  logic [7:0]  wb_adr_i,
	output var  logic [3:0]  wb_sel_i,
	output var  logic [31:0] wb_dat_i
);
	int hangs = 0;
	initial {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = '0;
	task automatic xfer(input logic w, input logic [7:0] a, input logic [3:0] s,
		input logic [31:0] d, output logic [31:0] q);
		int n;
		n = 0;
		@(posedge mclk);
		{wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} <= {2'b11, w, a, s, d};
		do begin
			@(posedge mclk);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 50);
		q = wb_dat_o;
		if (n >= 50) hangs++;
		// Released address and data lines show no stale value; we and sel keep theirs
		{wb_cyc_i, wb_stb_i, wb_adr_i, wb_dat_i} <= {2'b00, ~a, ~d};
	endtask
endmodule // hif_host
`default_nettype wire

// >>> hif_regs_test.sv
// Self-checking bench for the host register bank
`timescale 1ns/10ps
`default_nettype none
module hif_regs_test;
	localparam logic [31:0] EN_MASK = 32'h83bf_efff;
	localparam logic [2:0]  PAD [4] = '{3'd0, 3'd3, 3'd7, 3'd0};
	logic        mclk = 1'b0, resetn = 1'b0, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, host_irq;
	logic [7:0]  wb_adr_i, tx_data_free_blocks, tx_status_used, rx_data_free_blocks, rx_status_used;
	logic [3:0]  wb_sel_i;
	logic [31:0] wb_dat_i, wb_dat_o, interrupt_status_register;
	logic        tx_space_available_irq, tx_status_level_irq, rx_data_level_irq;
	logic        rx_status_level_irq, rx_dword_read, rx_buffer_end, rx_dma_done;
	logic        rx_fifo_flush, rx_pad_valid;
	logic [2:0]  rx_buffer_dwords, rx_pad_dwords;
	logic [1:0]  rx_end_align;
	logic [4:0]  receive_start_offset;
	int          miscompares = 0, samples_checked = 0, dones = 0, flushes = 0;
	wire logic [3:0] lv = {tx_space_available_irq, tx_status_level_irq,
		rx_data_level_irq, rx_status_level_irq};
	hif_regs i_hif_regs (.mclk, .resetn, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
		.wb_dat_i, .wb_dat_o, .wb_ack_o, .interrupt_status_register, .host_irq,
		.tx_data_free_blocks, .tx_status_used, .rx_data_free_blocks, .rx_status_used,
		.tx_space_available_irq, .tx_status_level_irq, .rx_data_level_irq,
		.rx_status_level_irq, .rx_dword_read, .rx_buffer_end, .rx_buffer_dwords,
		.rx_dma_done, .rx_fifo_flush, .rx_end_align, .rx_pad_dwords, .rx_pad_valid,
		.receive_start_offset);
	hif_host i_hif_host (.mclk, .wb_ack_o, .wb_dat_o, .wb_cyc_i, .wb_stb_i, .wb_we_i,
		.wb_adr_i, .wb_sel_i, .wb_dat_i);
	always #2 mclk = ~mclk;
	always @(posedge mclk) begin
		if (rx_dma_done === 1'b1) dones++;
		if (rx_fifo_flush === 1'b1) flushes++;
	end
	// ==========================================================
	// Tasks
	task automatic give_verdict();
		miscompares += i_hif_host.hangs;
		if (miscompares == 0 && samples_checked > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			miscompares++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [3:0] s,
		input logic [31:0] d, input logic [31:0] e);
		logic [31:0] q;
		i_hif_host.xfer(w, a, s, d, q);
		if (i_hif_host.hangs != 0) give_verdict();
		if (!w) chk($sformatf("read %h", a), e, q);
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
	endtask
	task automatic pulse_read();
		rx_dword_read <= 1'b1;
		tick(1);
		rx_dword_read <= 1'b0;
		tick(1);
	endtask
	// ==========================================================
	// Sequence
	initial begin
		interrupt_status_register = '0;
		{tx_data_free_blocks, tx_status_used, rx_status_used} = '0;
		rx_data_free_blocks = 8'hff;
		{rx_dword_read, rx_buffer_end, rx_buffer_dwords} = '0;
		tick(8);
		resetn <= 1'b1;
		bus(0, hif_pkg::ADDR_IRQ_ENABLE, 4'hf, 0, 32'h0000_0000);
		bus(0, hif_pkg::ADDR_FIFO_THRESH, 4'hf, 0, 32'h4800_0000);
		bus(1, hif_pkg::ADDR_BYTE_ORDER, 4'hf, 32'h0000_0000, 0);
		bus(0, hif_pkg::ADDR_BYTE_ORDER, 4'hf, 0, 32'h8765_4321);
		bus(0, 8'h70, 4'hf, 0, 32'h0000_0000);
		for (int i = 0; i < 32; i++) begin
			bus(1, hif_pkg::ADDR_IRQ_ENABLE, 4'hf, 32'h0000_0001 << i, 0);
			interrupt_status_register <= ~(32'h0000_0001 << i);
			tick(2);
			chk("irq masked", 32'h0000_0000, {31'h0, host_irq});
			interrupt_status_register <= 32'h0000_0001 << i;
			tick(2);
			chk("irq enabled", {31'h0, EN_MASK[i]}, {31'h0, host_irq});
		end
		bus(1, hif_pkg::ADDR_IRQ_ENABLE, 4'hf, 32'hffff_ffff, 0);
		bus(0, hif_pkg::ADDR_IRQ_ENABLE, 4'hf, 0, EN_MASK);
		bus(1, hif_pkg::ADDR_FIFO_THRESH, 4'hf, 32'h1020_3040, 0);
		{tx_data_free_blocks, tx_status_used, rx_data_free_blocks, rx_status_used} <= 32'h1020_3040;
		tick(2);
		chk("levels at", 32'h0000_0000, {28'h0, lv});
		{tx_data_free_blocks, tx_status_used, rx_data_free_blocks, rx_status_used} <= 32'h1121_2f41;
		tick(2);
		chk("levels past", 32'h0000_000f, {28'h0, lv});
		rx_data_free_blocks <= 8'hff;
		for (int c = 0; c < 4; c++) begin
			// Alignment only touched between packets
			bus(1, hif_pkg::ADDR_RX_CONFIG, 4'h8, 32'(c) << 30, 0);
			{rx_buffer_dwords, rx_buffer_end} <= 4'h3;
			tick(1);
			rx_buffer_end <= 1'b0;
			tick(1);
			chk("pad", {26'h0, 1'b1, 2'(c), PAD[c]}, {26'h0, rx_pad_valid, rx_end_align, rx_pad_dwords});
		end
		bus(1, hif_pkg::ADDR_RX_CONFIG, 4'hc, 32'h0003_0000, 0);
		pulse_read();
		pulse_read();
		bus(0, hif_pkg::ADDR_RX_CONFIG, 4'hf, 0, 32'h0001_0000);
		bus(1, hif_pkg::ADDR_RX_CONFIG, 4'hc, 32'h0002_0000, 0);
		pulse_read();
		chk("dma early", 0, dones);
		pulse_read();
		tick(1);
		chk("dma done", 1, dones);
		bus(1, hif_pkg::ADDR_RX_CONFIG, 4'hd, 32'h0000_8000, 0);
		bus(1, hif_pkg::ADDR_RX_CONFIG, 4'h2, 32'h0000_8000, 0);
		tick(2);
		chk("flushes", 1, flushes);
		// Receiver idle, so low offset bits may change
		bus(1, hif_pkg::ADDR_RX_CONFIG, 4'h2, 32'h0000_1600, 0);
		tick(2);
		chk("offset low", 32'h0000_0002, {27'h0, receive_start_offset});
		pulse_read();
		tick(1);
		chk("offset full", 32'h0000_0016, {27'h0, receive_start_offset});
		give_verdict();
	end
endmodule // hif_regs_test
`default_nettype wire
